// ==== ir_rx_frame_status_unit.v ====
// receive frame length limit, byte counter, control register two and status queue
`timescale 1ns/100ps
`default_nettype none
`include "ir_rx_frame_status_map.vh"

module ir_rx_frame_status_unit #(
	parameter DEPTH          = 8,
	parameter PTR_W          = 3,
	parameter TIMEOUT_CYCLES = 16'd1000
) (
	// apb
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// receiver events, same clock
	input  wire        rx_byte,
	input  wire        rx_frame_start,
	input  wire        rx_frame_end,
	input  wire        rx_crc_bad,
	input  wire        rx_encoding_error,
	input  wire        rx_abort,
	input  wire        rx_data_overrun,
	input  wire        rx_soft_reset,
	input  wire        fast_mode,
	input  wire        medium_mode,
	input  wire        dma_enable,
	// infrared path controls
	input  wire        tx_active,
	input  wire        rx_primary_pin,
	input  wire        rx_aux_pin,
	output wire        rx_in,
	output wire        rx_masked,
	output wire        medium_half_rate,
	output wire        tx_stop_select,
	output wire        frame_end_dma,
	output wire        counter_test,
	output wire        length_exceeded,
	output wire        status_irq
);

	reg [12:0] rx_max_length_q;
	reg [12:0] rx_byte_count_q;
	reg [7:0]  ir_control_two_q;
	reg [7:0]  ir_control_one_q;
	reg [7:0]  status_mem [0:DEPTH-1];
	reg [12:0] length_mem [0:DEPTH-1];
	reg [PTR_W-1:0] rd_ptr_q;
	reg [PTR_W-1:0] wr_ptr_q;
	reg [PTR_W:0]   level_q;
	reg [7:0]  lost_count_q;
	reg        lost_pend_q;
	reg        err_len_q;
	reg        err_phy_q;
	reg        err_crc_q;
	reg        err_ovr_q;
	reg        in_frame_q;
	reg [15:0] timeout_cnt_q;
	reg        timeout_q;
	reg [2:0]  prim_sync_q;
	reg [2:0]  aux_sync_q;
	reg        prim_q;
	reg        aux_q;

	wire       access_w = psel & penable & pwrite;
	wire       access_r = psel & penable & ~pwrite;
	wire [9:0] widx     = paddr[11:2];
	wire       mapped   = (widx >= {7'h0, `IDX_IR_CONTROL_TWO}) && (widx <= {6'h0, `IDX_RX_CONTROL});
	wire       q_mode   = fast_mode | medium_mode;
	wire       q_empty  = (level_q == {(PTR_W+1){1'b0}});
	wire       q_full   = (level_q == DEPTH[PTR_W:0]);
	wire       pop      = access_r && (widx == {7'h0, `IDX_RX_LEN_HIGH}) && !q_empty;
	wire       flush    = rx_soft_reset;
	wire       can_push = q_mode & dma_enable;
	wire       frame_ok = rx_frame_end & can_push & !q_full;
	wire       frame_lost = rx_frame_end & can_push & q_full;
	// lost-frame entry goes in once space frees and no frame end or pop lands in the same cycle
	wire       lost_push = lost_pend_q & !q_full & !rx_frame_end & !pop;
	wire       push     = frame_ok | lost_push;
	wire [7:0] bottom_st = status_mem[rd_ptr_q];
	wire [12:0] bottom_len = length_mem[rd_ptr_q];
	wire [12:0] next_count = rx_byte_count_q + 13'h0001;
	wire [3:0] threshold = ir_control_two_q[`C2_THRESHOLD_SEL] ? `THRESHOLD_HIGH : `THRESHOLD_LOW;

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// frame longer than the programmed limit
	assign length_exceeded  = in_frame_q && (rx_byte_count_q > rx_max_length_q);
	assign counter_test     = ir_control_one_q[`C1_COUNTER_TEST];
	assign rx_masked        = tx_active & ~ir_control_two_q[`C2_FULL_DUPLEX];
	assign medium_half_rate = ir_control_two_q[`C2_MEDIUM_RATE];
	assign tx_stop_select   = ir_control_two_q[`C2_TX_STOP] & q_mode;
	assign frame_end_dma    = ir_control_two_q[`C2_FRAME_END];
	assign rx_in = (ir_control_two_q[`C2_AUX_RX] ? aux_q : prim_q) | rx_masked;
	assign status_irq = q_mode && ((level_q >= threshold) || timeout_q);

	// pins pass three stages; a change counts when the last two agree
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prim_sync_q <= 3'h7;
			aux_sync_q  <= 3'h7;
			prim_q      <= 1'b1;
			aux_q       <= 1'b1;
		end else begin
			prim_sync_q <= {prim_sync_q[1:0], rx_primary_pin};
			aux_sync_q  <= {aux_sync_q[1:0], rx_aux_pin};
			if (prim_sync_q[2] == prim_sync_q[1])
				prim_q <= prim_sync_q[2];
			if (aux_sync_q[2] == aux_sync_q[1])
				aux_q <= aux_sync_q[2];
		end
	end

	// control registers and limit
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_max_length_q  <= `RX_MAX_LENGTH_RESET;
			ir_control_two_q <= `IR_CONTROL_TWO_RESET;
			ir_control_one_q <= 8'h00;
		end else if (access_w) begin
			case (widx)
			{7'h0, `IDX_IR_CONTROL_TWO}: begin
				ir_control_two_q <= (pwdata[7:0] & `IR_CONTROL_TWO_WMASK) | `IR_CONTROL_TWO_FORCE;
			end
			{6'h0, `IDX_RX_LIMIT_LOW}: begin
				rx_max_length_q[7:0] <= pwdata[7:0];
			end
			{6'h0, `IDX_RX_LIMIT_HIGH}: begin
				// upper three bits dropped, software writes them zero
				rx_max_length_q[12:8] <= pwdata[4:0];
			end
			{6'h0, `IDX_IR_CONTROL_ONE}: begin
				ir_control_one_q <= {4'h0, pwdata[3:0]};
			end
			default: begin
			end
			endcase
		end
	end

	// byte counter and per-frame error accumulation
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_byte_count_q <= 13'h0000;
			in_frame_q      <= 1'b0;
			err_len_q       <= 1'b0;
			err_phy_q       <= 1'b0;
			err_crc_q       <= 1'b0;
			err_ovr_q       <= 1'b0;
		end else if (flush || rx_frame_start || rx_frame_end) begin
			rx_byte_count_q <= rx_frame_start ? 13'h0000 : rx_byte_count_q;
			in_frame_q      <= rx_frame_start;
			err_len_q       <= 1'b0;
			err_phy_q       <= 1'b0;
			err_crc_q       <= 1'b0;
			err_ovr_q       <= 1'b0;
		end else if (in_frame_q) begin
			if (rx_byte)
				rx_byte_count_q <= next_count;
			if (length_exceeded)
				err_len_q <= 1'b1;
			if ((fast_mode & rx_encoding_error) | (medium_mode & rx_abort))
				err_phy_q <= 1'b1;
			if (rx_data_overrun)
				err_ovr_q <= 1'b1;
		end
	end

	// crc check arrives with the frame end, so it is folded into the entry directly
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lost_count_q <= 8'h00;
		else if (flush || lost_push)
			lost_count_q <= 8'h00;
		else if (frame_lost && lost_count_q != 8'hff)
			lost_count_q <= lost_count_q + 8'h01;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lost_pend_q <= 1'b0;
		else if (flush || lost_push)
			lost_pend_q <= 1'b0;
		else if (frame_lost)
			lost_pend_q <= 1'b1;
	end

	// status queue storage, one entry per slot
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi = gi + 1) begin : slot
			always @(posedge pclk) begin
				if (push && wr_ptr_q == gi) begin
					status_mem[gi] <= lost_push ?
						{1'b1, 1'b1, 5'h00, 1'b1} :
						{1'b1, 1'b0, 1'b0, err_len_q | length_exceeded, err_phy_q,
						 rx_crc_bad, err_ovr_q | rx_data_overrun, 1'b0};
					length_mem[gi] <= lost_push ? {5'h00, lost_count_q} : rx_byte_count_q;
				end
			end
		end
	endgenerate

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_ptr_q <= {PTR_W{1'b0}};
			wr_ptr_q <= {PTR_W{1'b0}};
			level_q  <= {(PTR_W+1){1'b0}};
		end else if (flush) begin
			rd_ptr_q <= {PTR_W{1'b0}};
			wr_ptr_q <= {PTR_W{1'b0}};
			level_q  <= {(PTR_W+1){1'b0}};
		end else begin
			if (push)
				wr_ptr_q <= wr_ptr_q + {{(PTR_W-1){1'b0}}, 1'b1};
			if (pop)
				rd_ptr_q <= rd_ptr_q + {{(PTR_W-1){1'b0}}, 1'b1};
			if (push && !pop)
				level_q <= level_q + {{PTR_W{1'b0}}, 1'b1};
			else if (pop && !push)
				level_q <= level_q - {{PTR_W{1'b0}}, 1'b1};
		end
	end

	// timeout runs while the queue holds any entry, restarts on pop
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timeout_cnt_q <= 16'h0000;
			timeout_q     <= 1'b0;
		end else if (flush || pop || q_empty) begin
			timeout_cnt_q <= 16'h0000;
			timeout_q     <= 1'b0;
		end else if (timeout_cnt_q >= TIMEOUT_CYCLES - 16'd1) begin
			timeout_q <= 1'b1;
		end else begin
			timeout_cnt_q <= timeout_cnt_q + 16'h0001;
		end
	end

	// read mux, data registered on the setup cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			case (widx)
			{7'h0, `IDX_IR_CONTROL_TWO}: prdata <= {24'h0, ir_control_two_q};
			{7'h0, `IDX_FRAME_STATUS}: begin
				prdata <= q_empty ? 32'h00000000 : {24'h0, bottom_st};
			end
			{7'h0, `IDX_RX_LEN_LOW_LOST}: begin
				prdata <= q_empty ? 32'h00000000 : {24'h0, bottom_len[7:0]};
			end
			{7'h0, `IDX_RX_LEN_HIGH}: begin
				// lost entry holds zero in the upper length bits
				prdata <= q_empty ? 32'h00000000 : {27'h0, bottom_len[12:8]};
			end
			{6'h0, `IDX_RX_LIMIT_LOW}: begin
				prdata <= {24'h0, counter_test ? rx_max_length_q[7:0] : rx_byte_count_q[7:0]};
			end
			{6'h0, `IDX_RX_LIMIT_HIGH}: begin
				prdata <= {27'h0, counter_test ? rx_max_length_q[12:8] : rx_byte_count_q[12:8]};
			end
			{6'h0, `IDX_IR_CONTROL_ONE}: prdata <= {24'h0, ir_control_one_q};
			{6'h0, `IDX_RX_CONTROL}: begin
				prdata <= {20'h0, lost_count_q, timeout_q, level_q[2:0] & 3'h7};
			end
			default: prdata <= 32'h00000000;
			endcase
		end
	end

endmodule
`default_nettype wire

// ==== ir_rx_frame_status_map.vh ====
// register offsets, field positions, reset values and thresholds of the receive frame status unit
`ifndef IR_RX_FRAME_STATUS_MAP_VH
`define IR_RX_FRAME_STATUS_MAP_VH

// byte indices as printed; byte address is four times the index
`define IDX_IR_CONTROL_TWO     3'h4
`define IDX_FRAME_STATUS       3'h5
`define IDX_RX_LEN_LOW_LOST    3'h6
`define IDX_RX_LEN_HIGH        3'h7
// locally placed registers (indices in a second block of eight)
`define IDX_RX_LIMIT_LOW       4'h8
`define IDX_RX_LIMIT_HIGH      4'h9
`define IDX_IR_CONTROL_ONE     4'ha
`define IDX_RX_CONTROL         4'hb

`define RX_MAX_LENGTH_RESET    13'h0800
`define IR_CONTROL_TWO_RESET   8'h02
`define IR_CONTROL_TWO_WMASK   8'h7d
`define IR_CONTROL_TWO_FORCE   8'h02

`define C2_FULL_DUPLEX         0
`define C2_MEDIUM_RATE         2
`define C2_TX_STOP             3
`define C2_AUX_RX              4
`define C2_FRAME_END           5
`define C2_THRESHOLD_SEL       6
`define C1_COUNTER_TEST        1

`define ST_ENTRY_VALID         7
`define ST_LOST_FRAME          6
`define ST_LENGTH_EXCEEDED     4
`define ST_PHYSICAL_ERROR      3
`define ST_CRC_ERROR           2
`define ST_RX_OVERRUN          1
`define ST_STATUS_OVERRUN      0

`define THRESHOLD_LOW          4'h2
`define THRESHOLD_HIGH         4'h4

`endif

// ==== ir_rx_frame_status_sva.sv ====
// assertion checker for the receive frame status unit
`timescale 1ns/100ps
`default_nettype none
`include "ir_rx_frame_status_map.vh"
module ir_rx_frame_status_sva (
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// receiver and infrared path
	input wire logic        rx_frame_start,
	input wire logic        fast_mode,
	input wire logic        medium_mode,
	input wire logic        tx_active,
	input wire logic        rx_in,
	input wire logic        rx_masked,
	input wire logic        medium_half_rate,
	input wire logic        tx_stop_select,
	input wire logic        frame_end_dma,
	input wire logic        counter_test,
	input wire logic        length_exceeded,
	input wire logic        status_irq
);
	logic [7:0]  c2_q;
	logic        counter_test_q;
	logic [12:0] lim_q;
	// shadow of what software wrote, independent of the design's registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c2_q <= `IR_CONTROL_TWO_RESET;
			counter_test_q <= 1'b0;
			lim_q <= `RX_MAX_LENGTH_RESET;
		end else if (psel && penable && pwrite && paddr[11:6] == 6'h00) begin
			case (paddr[5:2])
				4'h4: c2_q <= (pwdata[7:0] & 8'h7d) | 8'h02;
				4'h8: lim_q[7:0] <= pwdata[7:0];
				4'h9: lim_q[12:8] <= pwdata[4:0];
				4'ha: counter_test_q <= pwdata[1];
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_read(logic [3:0] idx);
		psel && penable && !pwrite && paddr[11:2] == {6'h00, idx};
	endsequence
	property p_mask;
		rx_masked == (tx_active && !c2_q[0]);
	endproperty
	property p_idle;
		rx_masked |-> rx_in;
	endproperty
	property p_rate;
		medium_half_rate == c2_q[2];
	endproperty
	property p_stop;
		tx_stop_select == (c2_q[3] && (fast_mode || medium_mode));
	endproperty
	property p_fend;
		frame_end_dma == c2_q[5];
	endproperty
	property p_counter_test;
		counter_test == counter_test_q;
	endproperty
	property p_c2_rd;
		s_read(4'h4) |-> prdata[7:0] == c2_q;
	endproperty
	property p_lim_lo;
		(s_read(4'h8) ##0 counter_test_q) |-> prdata[7:0] == lim_q[7:0];
	endproperty
	property p_lim_hi;
		(s_read(4'h9) ##0 counter_test_q) |-> prdata[7:0] == {3'b000, lim_q[12:8]};
	endproperty
	property p_irq_off;
		!(fast_mode || medium_mode) |-> !status_irq;
	endproperty
	property p_len_start;
		rx_frame_start |=> !length_exceeded;
	endproperty
	a_mask: assert property (p_mask) else $error("receive mask wrong");
	a_idle: assert property (p_idle) else $error("masked input not idle");
	a_rate: assert property (p_rate) else $error("medium rate select wrong");
	a_stop: assert property (p_stop) else $error("stop select wrong");
	a_fend: assert property (p_fend) else $error("frame end control wrong");
	a_counter_test: assert property (p_counter_test) else $error("counter test wrong");
	a_c2_rd: assert property (p_c2_rd) else $error("control two read wrong");
	a_lim_lo: assert property (p_lim_lo) else $error("limit low read wrong");
	a_lim_hi: assert property (p_lim_hi) else $error("limit high read wrong");
	a_irq_off: assert property (p_irq_off) else $error("irq outside queue modes");
	a_len_start: assert property (p_len_start) else $error("length flag at start");
endmodule
bind ir_rx_frame_status_unit ir_rx_frame_status_sva chk (.*);
`default_nettype wire

// ==== ir_optics_model.sv ====
// receiver-side model of the infrared optics and decoder events
`timescale 1ns/100ps
`default_nettype none
module ir_optics_model (
	// clock
	input  wire logic pclk,
	// decoded receive events
	output logic      rx_byte,
	output logic      rx_frame_start,
	output logic      rx_frame_end,
	output logic      rx_crc_bad,
	output logic      rx_abort,
	// raw optical inputs
	output logic      rx_primary_pin,
	output logic      rx_aux_pin
);
	initial {rx_byte, rx_frame_start, rx_frame_end, rx_crc_bad, rx_abort} = 5'h00;
	// raw pins never settle, so a stale synchroniser shows up
	always @(posedge pclk) begin
		rx_primary_pin <= 1'($urandom_range(1, 0));
		rx_aux_pin <= ~rx_primary_pin;
	end
	task open_frame(input int n);
		@(posedge pclk);
		rx_frame_start <= 1'b1;
		@(posedge pclk);
		rx_frame_start <= 1'b0;
		repeat (n) begin
			@(posedge pclk);
			rx_byte <= 1'b1;
			@(posedge pclk);
			rx_byte <= 1'b0;
		end
	endtask
	task close_frame(input logic crc, input logic abrt);
		@(posedge pclk);
		rx_abort <= abrt;
		@(posedge pclk);
		rx_abort <= 1'b0;
		rx_crc_bad <= crc;
		rx_frame_end <= 1'b1;
		@(posedge pclk);
		rx_frame_end <= 1'b0;
		rx_crc_bad <= ~crc;
		@(posedge pclk);
	endtask
endmodule
`default_nettype wire

// ==== ir_rx_frame_status_unit_tb.sv ====
// self-checking bench for the receive frame status unit
`timescale 1ns/100ps
`default_nettype none
module ir_rx_frame_status_unit_tb;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic        rx_soft_reset = 0, medium_mode = 0, dma_enable = 0, tx_active = 0;
	wire  [31:0] prdata;
	wire         pready, rx_byte, rx_frame_start, rx_frame_end, rx_crc_bad, rx_abort;
	wire         rx_primary_pin, rx_aux_pin, status_irq;
	int          fail_count = 0, total_checks = 0;
	logic [31:0] exp_q[$];
	logic [12:0] lim;
	logic [7:0]  r;
	logic [7:0]  st[3] = '{8'h84, 8'h90, 8'h88};
	logic [7:0]  ln[3] = '{8'h04, 8'h07, 8'h03};
	always #2 pclk = ~pclk;
	always @(posedge pclk) tx_active <= 1'($urandom_range(1, 0));
	ir_rx_frame_status_unit #(.TIMEOUT_CYCLES(16'd2000)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(), .rx_byte(rx_byte),
		.rx_frame_start(rx_frame_start), .rx_frame_end(rx_frame_end), .rx_crc_bad(rx_crc_bad),
		.rx_encoding_error(1'b0), .rx_abort(rx_abort), .rx_data_overrun(1'b0),
		.rx_soft_reset(rx_soft_reset), .fast_mode(1'b0), .medium_mode(medium_mode),
		.dma_enable(dma_enable), .tx_active(tx_active), .rx_primary_pin(rx_primary_pin),
		.rx_aux_pin(rx_aux_pin), .rx_in(), .rx_masked(), .medium_half_rate(),
		.tx_stop_select(), .frame_end_dma(), .counter_test(), .length_exceeded(),
		.status_irq(status_irq));
	ir_optics_model optics (.pclk(pclk), .rx_byte(rx_byte), .rx_frame_start(rx_frame_start),
		.rx_frame_end(rx_frame_end), .rx_crc_bad(rx_crc_bad), .rx_abort(rx_abort),
		.rx_primary_pin(rx_primary_pin), .rx_aux_pin(rx_aux_pin));
	task check(input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task stop_test;
		if (fail_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task xfer(input logic [3:0] idx, input logic wr, input logic [7:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {6'h00, idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (n >= 64)
			fail_count++;
		if (n >= 64)
			stop_test();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rd(input logic [3:0] idx, input logic [7:0] e);
		exp_q.push_back({24'h000000, e});
		xfer(idx, 1'b0, 8'h00);
	endtask
	task frame(input int n, input logic crc, input logic abrt);
		optics.open_frame(n);
		optics.close_frame(crc, abrt);
	endtask
	// read data is judged where the access completes, against the oldest note
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready === 1'b1)
			check(prdata, exp_q.pop_front());
	end
	initial begin
		int i;
		void'($urandom(32'h3bc9));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(4'h4, 8'h02);
		rd(4'h5, 8'h00);
		rd(4'h0, 8'h00);
		xfer(4'ha, 1'b1, 8'h02);
		rd(4'h8, 8'h00);
		rd(4'h9, 8'h08);
		r = 8'($urandom);
		xfer(4'h4, 1'b1, r);
		rd(4'h4, (r & 8'h7d) | 8'h02);
		lim = 13'($urandom_range(8191, 4));
		xfer(4'h8, 1'b1, lim[7:0]);
		xfer(4'h9, 1'b1, {3'b000, lim[12:8]});
		rd(4'h8, lim[7:0]);
		rd(4'h9, {3'b000, lim[12:8]});
		xfer(4'ha, 1'b1, 8'h00);
		optics.open_frame(19);
		rd(4'h8, 8'd19);
		rd(4'h9, 8'h00);
		optics.close_frame(1'b0, 1'b0);
		rd(4'h5, 8'h00);
		medium_mode <= 1'b1;
		dma_enable <= 1'b1;
		xfer(4'h8, 1'b1, 8'h05);
		xfer(4'h9, 1'b1, 8'h00);
		xfer(4'h4, 1'b1, 8'h42);
		frame(4, 1'b1, 1'b0);
		frame(7, 1'b0, 1'b0);
		frame(3, 1'b0, 1'b1);
		check({31'd0, status_irq}, 32'd0);
		for (i = 0; i < 3; i++) begin
			rd(4'h5, st[i]);
			rd(4'h6, ln[i]);
			rd(4'h7, 8'h00);
		end
		rd(4'h5, 8'h00);
		for (i = 1; i <= 9; i++)
			frame(i, 1'b0, 1'b0);
		check({31'd0, status_irq}, 32'd1);
		for (i = 1; i <= 9; i++) begin
			rd(4'h5, (i > 8) ? 8'hc1 : ((i > 5) ? 8'h90 : 8'h80));
			rd(4'h6, (i > 8) ? 8'h01 : 8'(i));
			rd(4'h7, 8'h00);
		end
		xfer(4'h4, 1'b1, 8'h02);
		frame(2, 1'b0, 1'b0);
		frame(2, 1'b0, 1'b0);
		check({31'd0, status_irq}, 32'd1);
		rx_soft_reset <= 1'b1;
		@(posedge pclk);
		rx_soft_reset <= 1'b0;
		@(posedge pclk);
		rd(4'h5, 8'h00);
		frame(1, 1'b0, 1'b0);
		check({31'd0, status_irq}, 32'd0);
		repeat (2010) @(posedge pclk);
		check({31'd0, status_irq}, 32'd1);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(4'h5, 8'h00);
		rd(4'hc, 8'h00);
		stop_test();
	end
endmodule
`default_nettype wire
